// >>> core/cadc_ctrl.sv
// analog enable, gain and result scaling outputs derived from the option byte and operating conditions
module cadc_ctrl
	import cadc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// option byte and conditions
	cadc_opt_if.ctrl         opt,
	// analog controls
	output logic             bat_mon_buf_en_o,
	output logic             lp_hot_en_o,
	output logic             sps_en_o,
	output logic [1:0]       sps_cfg_o,
	output logic             sps_gain_o,
	output logic             input_sel_o,
	output logic             charge_sel_o,
	// result scaling
	output logic [9:0]       charge_lsb_o,
	output logic [9:0]       discharge_lsb_o,
	output logic [9:0]       input_lsb_o,
	output logic [3:0]       compare_lsb_o,
	output logic [13:0]      volt_offset_o
);
	logic       lp;
	logic [1:0] cfg;

	assign lp  = opt.low_power_mode_enable;
	assign cfg = opt.option_hi[SPS_CFG_HI_BIT:SPS_CFG_LO_BIT];

	// register every control so the top outputs come from flip-flops
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bat_mon_buf_en_o <= CHARGE_OPTION_RESET[8 + BAT_MON_EN_BIT];
			lp_hot_en_o      <= CHARGE_OPTION_RESET[8 + LP_HOT_EN_BIT];
			sps_en_o         <= 1'b0;
			sps_cfg_o        <= CHARGE_OPTION_RESET[8 + SPS_CFG_HI_BIT -: 2];
			sps_gain_o       <= CHARGE_OPTION_RESET[8 + SPS_GAIN_BIT];
			input_sel_o      <= CHARGE_OPTION_RESET[8 + INPUT_SEL_BIT];
			charge_sel_o     <= CHARGE_OPTION_RESET[8 + CHARGE_SEL_BIT];
			charge_lsb_o     <= CHARGE_LSB_5M_MA;
			discharge_lsb_o  <= DISCHARGE_LSB_5M_MA;
			input_lsb_o      <= INPUT_LSB_5M_MA;
			compare_lsb_o    <= COMPARE_LSB_LOW_MV;
			volt_offset_o    <= VOLT_OFFSET_4S_MV;
		end
		else if (ce_i)
		begin
			bat_mon_buf_en_o <= opt.option_hi[BAT_MON_EN_BIT] & ~lp; // R09 R10
			lp_hot_en_o      <= opt.option_hi[LP_HOT_EN_BIT]; // R11
			sps_en_o         <= ~lp && (cfg == SPS_BUS_PLUS_BAT ||
			                            cfg == SPS_BUS_ONLY); // R12 R13
			sps_cfg_o        <= cfg; // R12
			sps_gain_o       <= opt.option_hi[SPS_GAIN_BIT]; // R16
			input_sel_o      <= opt.option_hi[INPUT_SEL_BIT]; // R14
			charge_sel_o     <= opt.option_hi[CHARGE_SEL_BIT]; // R15
			charge_lsb_o     <= opt.option_hi[CHARGE_SEL_BIT] ?
			                    CHARGE_LSB_5M_MA : CHARGE_LSB_10M_MA; // R01
			discharge_lsb_o  <= opt.option_hi[CHARGE_SEL_BIT] ?
			                    DISCHARGE_LSB_5M_MA :
			                    DISCHARGE_LSB_10M_MA; // R02
			input_lsb_o      <= opt.option_hi[INPUT_SEL_BIT] ?
			                    INPUT_LSB_5M_MA : INPUT_LSB_10M_MA; // R05
			compare_lsb_o    <= opt.converter_full_scale_select ?
			                    COMPARE_LSB_HIGH_MV : COMPARE_LSB_LOW_MV; // R06
			volt_offset_o    <= opt.five_cell ?
			                    VOLT_OFFSET_5S_MV : VOLT_OFFSET_4S_MV; // R07 R08
		end
	end
endmodule

// >>> core/cadc_result.sv
// read-only measurement result holder with full-scale saturation
module cadc_result
	import cadc_pkg::*;
#(
	parameter int IN_W  = 8,
	parameter int OUT_W = 8
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             ce_i,
	// conversion input
	input  wire logic             load_i,
	input  wire logic [IN_W-1:0]  code_i,
	// held result
	output logic      [OUT_W-1:0] result_o
);
	localparam logic [IN_W-1:0] FULL_CODE = IN_W'({OUT_W{1'b1}});

	logic [OUT_W-1:0] next_result;

	// clamp to full scale instead of wrapping
	always_comb
	begin
		if (code_i > FULL_CODE)
			next_result = {OUT_W{1'b1}}; // R03
		else
			next_result = code_i[OUT_W-1:0];
	end

	// keep the last finished conversion until the next one
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			result_o <= RESULT_RESET[OUT_W-1:0];
		else if (ce_i && load_i)
			result_o <= next_result; // R17
	end
endmodule

// >>> core/cadc_top.sv
// serial-bus register bank for measurement results and the option upper byte
// How it works
// R01 - charge current code in low seven bits, 64 or 128 mA per step
// R02 - discharge current code in low seven bits, 256 or 512 mA per step
// R03 - discharge result clamps at full-scale code instead of wrapping
// R04 - top bit of both current bytes unused; reads zero, host ignores it
// R05 - input current eight-bit code, 50 or 100 mA per step
// R06 - comparator pin voltage code, 12 mV or 8 mV per step
// R07 - system voltage code, 64 mV steps, offset by cell count
// R08 - battery voltage code, 64 mV steps, span by cell count
// R09 - bit 7 turns battery current monitor buffer on, default off
// R10 - low power mode forces battery current monitor buffer off
// R11 - bit 6 enables low power hot signalling; host avoids with adapter
// R12 - bits 5:4 choose system power sensing mode, default off
// R13 - low power mode forces system power sensing off
// R14 - bit 3 picks input sense resistor, default 5 milliohm
// R15 - bit 2 picks charge sense resistor, default 5 milliohm
// R16 - bit 1 picks system power gain, default 1 uA per watt
// R17 - result bytes ignore writes and hold latest finished conversion
// R18 - bit 0 is plain read-write, resets to one
module cadc_top
	import cadc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary neutral value
)
(
	// clock, reset, enable
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    NRST_I,
	input  wire logic                    CE_I,
	// serial bus pins
	input  wire logic                    SCL_I,
	input  wire logic                    SDA_I,
	output logic                         SDA_O,
	output logic                         SDA_OE_O,
	// conversion results
	input  wire logic [NUM_CH-1:0]       CONV_DONE_I,
	input  wire logic [SHORT_CODE_W-1:0] CHARGE_CURRENT_I,
	input  wire logic [CODE_W-1:0]       DISCHARGE_CURRENT_I,
	input  wire logic [CODE_W-1:0]       INPUT_CURRENT_I,
	input  wire logic [CODE_W-1:0]       COMPARATOR_INPUT_PIN_I,
	input  wire logic [CODE_W-1:0]       SYSTEM_VOLTAGE_I,
	input  wire logic [CODE_W-1:0]       BATTERY_VOLTAGE_I,
	// operating conditions
	input  wire logic                    LOW_POWER_MODE_ENABLE_I,
	input  wire logic                    FIVE_CELL_I,
	input  wire logic                    CONVERTER_FULL_SCALE_SELECT_I,
	// analog controls
	output logic                         BATTERY_CURRENT_MONITOR_EN_O,
	output logic                         LOW_POWER_HOT_SIGNAL_EN_O,
	output logic                         SYSTEM_POWER_SENSE_EN_O,
	output logic [1:0]                   SYSTEM_POWER_SENSE_CONFIG_O,
	output logic                         SYSTEM_POWER_GAIN_SELECT_O,
	output logic                         INPUT_SENSE_RESISTOR_SELECT_O,
	output logic                         CHARGE_SENSE_RESISTOR_SELECT_O,
	// result scaling
	output logic [9:0]                   CHARGE_LSB_MA_O,
	output logic [9:0]                   DISCHARGE_LSB_MA_O,
	output logic [9:0]                   INPUT_LSB_MA_O,
	output logic [3:0]                   COMPARE_LSB_MV_O,
	output logic [13:0]                  VOLTAGE_OFFSET_MV_O
);
	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_PTR       = 9'h008,
		ST_PTR_ACK   = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RACK      = 9'h100
	} cadc_state_t;

	cadc_state_t              state;
	cadc_state_t              next_state;
	logic                     scl_q;
	logic                     sda_q;
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     start_cond;
	logic                     stop_cond;
	logic [3:0]               bit_cnt;
	logic [7:0]               shift;
	logic [7:0]               tx;
	logic [7:0]               ptr;
	logic                     rw;
	logic                     addr_match;
	logic                     byte_done;
	logic [7:0]               option_hi;
	logic [7:0]               read_byte;
	logic [SHORT_CODE_W-1:0]  charge_q;
	logic [SHORT_CODE_W-1:0]  discharge_q;
	logic [CODE_W-1:0]        input_q;
	logic [CODE_W-1:0]        compare_q;
	logic [CODE_W-1:0]        system_q;
	logic [CODE_W-1:0]        battery_q;

	cadc_opt_if opt ();

	// pin history for edge and bus condition detection
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else if (CE_I)
		begin
			scl_q <= SCL_I;
			sda_q <= SDA_I;
		end
	end

	// bus events seen this cycle
	assign scl_rise   = SCL_I & ~scl_q;
	assign scl_fall   = ~SCL_I & scl_q;
	assign start_cond = SCL_I & scl_q & sda_q & ~SDA_I;
	assign stop_cond  = SCL_I & scl_q & ~sda_q & SDA_I;
	assign byte_done  = scl_fall && (bit_cnt == BITS_PER_BYTE);
	assign addr_match = (shift[7:1] == DEV_ADDR);

	// transfer sequencing
	always_comb
	begin
		next_state = state;
		if (stop_cond)
			next_state = ST_IDLE;
		else if (start_cond)
			next_state = ST_ADDR;
		else
		begin
			unique case (state)
				ST_IDLE:
					next_state = ST_IDLE;
				ST_ADDR:
					if (byte_done)
						next_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
				ST_ADDR_ACK:
					if (scl_fall)
						next_state = rw ? ST_RDATA : ST_PTR;
				ST_PTR:
					if (byte_done)
						next_state = ST_PTR_ACK;
				ST_PTR_ACK:
					if (scl_fall)
						next_state = ST_WDATA;
				ST_WDATA:
					if (byte_done)
						next_state = ST_WDATA_ACK;
				ST_WDATA_ACK:
					if (scl_fall)
						next_state = ST_WDATA;
				ST_RDATA:
					if (byte_done)
						next_state = ST_RACK;
				ST_RACK:
					if (scl_rise && SDA_I)
						next_state = ST_IDLE;
					else if (scl_fall)
						next_state = ST_RDATA;
				default:
					next_state = ST_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			state <= ST_IDLE;
		else if (CE_I)
			state <= next_state;
	end

	// bit counter: received bits on rising edges, sent bits on falling edges
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			bit_cnt <= 4'h0;
		else if (CE_I)
		begin
			if (start_cond || stop_cond)
				bit_cnt <= 4'h0;
			else if (scl_rise && (state == ST_ADDR || state == ST_PTR ||
			                      state == ST_WDATA))
				bit_cnt <= bit_cnt + 4'h1;
			else if (scl_fall && (next_state == ST_RDATA) &&
			         (state != ST_RDATA))
				bit_cnt <= 4'h1;
			else if (scl_fall && state == ST_RDATA && !byte_done)
				bit_cnt <= bit_cnt + 4'h1;
			else if (scl_fall && (state == ST_ADDR_ACK ||
			                      state == ST_PTR_ACK ||
			                      state == ST_WDATA_ACK))
				bit_cnt <= 4'h0;
		end
	end

	// receive shifter and direction bit
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			shift <= 8'h00;
			rw    <= 1'b0;
		end
		else if (CE_I)
		begin
			if (scl_rise && (state == ST_ADDR || state == ST_PTR ||
			                 state == ST_WDATA))
				shift <= {shift[6:0], SDA_I};
			if (byte_done && state == ST_ADDR)
				rw <= shift[0];
		end
	end

	// register read selection; current top bits read as zero
	always_comb
	begin
		unique case (ptr)
			DISCHARGE_CURRENT_ADDR: read_byte = {1'b0, discharge_q}; // R04
			CHARGE_CURRENT_ADDR:    read_byte = {1'b0, charge_q}; // R04
			COMPARATOR_INPUT_ADDR:  read_byte = compare_q;
			INPUT_CURRENT_ADDR:     read_byte = input_q;
			BATTERY_VOLTAGE_ADDR:   read_byte = battery_q;
			SYSTEM_VOLTAGE_ADDR:    read_byte = system_q;
			CHARGE_OPTION_LO_ADDR:  read_byte = CHARGE_OPTION_LO_VALUE;
			CHARGE_OPTION_HI_ADDR:  read_byte = option_hi;
			default:                read_byte = UNMAPPED_VALUE;
		endcase
	end

	// register pointer: set by the pointer byte, steps after each data byte
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			ptr <= 8'h00;
		else if (CE_I)
		begin
			if (byte_done && state == ST_PTR)
				ptr <= shift;
			else if (byte_done && state == ST_WDATA)
				ptr <= ptr + 8'h01;
			else if (scl_fall && next_state == ST_RDATA &&
			         state != ST_RDATA)
				ptr <= ptr + 8'h01;
		end
	end

	// transmit shifter loaded at the start of each read byte
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			tx <= 8'h00;
		else if (CE_I)
		begin
			if (scl_fall && next_state == ST_RDATA && state != ST_RDATA)
				tx <= read_byte;
			else if (scl_fall && state == ST_RDATA)
				tx <= {tx[6:0], 1'b0};
		end
	end

	// open-drain data drive: acknowledge low, or zero data bits low
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			SDA_OE_O <= 1'b0;
			SDA_O    <= 1'b0;
		end
		else if (CE_I)
		begin
			SDA_O <= 1'b0;
			if (start_cond || stop_cond)
				SDA_OE_O <= 1'b0;
			else if (scl_fall)
			begin
				if (next_state == ST_ADDR_ACK || next_state == ST_PTR_ACK ||
				    next_state == ST_WDATA_ACK)
					SDA_OE_O <= 1'b1;
				else if (next_state == ST_RDATA && state != ST_RDATA)
					SDA_OE_O <= ~read_byte[7];
				else if (state == ST_RDATA && !byte_done)
					SDA_OE_O <= ~tx[6];
				else
					SDA_OE_O <= 1'b0;
			end
		end
	end

	// option upper byte; writes to result pointers change nothing
	always_ff @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			option_hi <= CHARGE_OPTION_RESET[15:8]; // R18
		else if (CE_I && byte_done && state == ST_WDATA &&
		         ptr == CHARGE_OPTION_HI_ADDR)
			option_hi <= shift; // R09 R11 R12 R14 R15 R16 R18
	end

	// measurement result holders
	cadc_result #(.IN_W(SHORT_CODE_W), .OUT_W(SHORT_CODE_W)) u_charge (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_CHARGE]),
		.code_i   (CHARGE_CURRENT_I), // R01
		.result_o (charge_q)
	);
	cadc_result #(.IN_W(CODE_W), .OUT_W(SHORT_CODE_W)) u_discharge (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_DISCHARGE]),
		.code_i   (DISCHARGE_CURRENT_I), // R02 R03
		.result_o (discharge_q)
	);
	cadc_result #(.IN_W(CODE_W), .OUT_W(CODE_W)) u_input (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_INPUT]),
		.code_i   (INPUT_CURRENT_I), // R05
		.result_o (input_q)
	);
	cadc_result #(.IN_W(CODE_W), .OUT_W(CODE_W)) u_compare (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_COMPARE]),
		.code_i   (COMPARATOR_INPUT_PIN_I), // R06
		.result_o (compare_q)
	);
	cadc_result #(.IN_W(CODE_W), .OUT_W(CODE_W)) u_system (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_SYSTEM]),
		.code_i   (SYSTEM_VOLTAGE_I), // R07
		.result_o (system_q)
	);
	cadc_result #(.IN_W(CODE_W), .OUT_W(CODE_W)) u_battery (
		.clk_i    (SYS_CLK_I),
		.nrst_i   (NRST_I),
		.ce_i     (CE_I),
		.load_i   (CONV_DONE_I[CH_BATTERY]),
		.code_i   (BATTERY_VOLTAGE_I), // R08
		.result_o (battery_q)
	);

	// option byte and conditions handed to the control outputs
	assign opt.option_hi                   = option_hi;
	assign opt.low_power_mode_enable       = LOW_POWER_MODE_ENABLE_I;
	assign opt.five_cell                   = FIVE_CELL_I;
	assign opt.converter_full_scale_select = CONVERTER_FULL_SCALE_SELECT_I;

	// analog enables and scaling outputs
	cadc_ctrl u_ctrl (
		.clk_i            (SYS_CLK_I),
		.nrst_i           (NRST_I),
		.ce_i             (CE_I),
		.opt              (opt.ctrl),
		.bat_mon_buf_en_o (BATTERY_CURRENT_MONITOR_EN_O),
		.lp_hot_en_o      (LOW_POWER_HOT_SIGNAL_EN_O),
		.sps_en_o         (SYSTEM_POWER_SENSE_EN_O),
		.sps_cfg_o        (SYSTEM_POWER_SENSE_CONFIG_O),
		.sps_gain_o       (SYSTEM_POWER_GAIN_SELECT_O),
		.input_sel_o      (INPUT_SENSE_RESISTOR_SELECT_O),
		.charge_sel_o     (CHARGE_SENSE_RESISTOR_SELECT_O),
		.charge_lsb_o     (CHARGE_LSB_MA_O),
		.discharge_lsb_o  (DISCHARGE_LSB_MA_O),
		.input_lsb_o      (INPUT_LSB_MA_O),
		.compare_lsb_o    (COMPARE_LSB_MV_O),
		.volt_offset_o    (VOLTAGE_OFFSET_MV_O)
	);
endmodule

// >>> pkg/cadc_opt_if.sv
// option byte and operating conditions passed from the bank to the control
interface cadc_opt_if;
	logic [7:0] option_hi;
	logic       low_power_mode_enable;
	logic       five_cell;
	logic       converter_full_scale_select;
	modport bank (output option_hi, low_power_mode_enable, five_cell,
	              converter_full_scale_select);
	modport ctrl (input option_hi, low_power_mode_enable, five_cell,
	              converter_full_scale_select);
endinterface

// >>> pkg/cadc_pkg.sv
// constants shared by the charger result and option register bank
package cadc_pkg;
	// register pointers
	localparam logic [7:0] DISCHARGE_CURRENT_ADDR = 8'h28;
	localparam logic [7:0] CHARGE_CURRENT_ADDR    = 8'h29;
	localparam logic [7:0] COMPARATOR_INPUT_ADDR  = 8'h2a;
	localparam logic [7:0] INPUT_CURRENT_ADDR     = 8'h2b;
	localparam logic [7:0] BATTERY_VOLTAGE_ADDR   = 8'h2c;
	localparam logic [7:0] SYSTEM_VOLTAGE_ADDR    = 8'h2d;
	localparam logic [7:0] CHARGE_OPTION_LO_ADDR  = 8'h30;
	localparam logic [7:0] CHARGE_OPTION_HI_ADDR  = 8'h31;
	// reset values
	localparam logic [15:0] CHARGE_OPTION_RESET    = 16'h3f00;
	localparam logic [7:0]  CHARGE_OPTION_LO_VALUE = 8'h00;
	localparam logic [7:0]  RESULT_RESET           = 8'h00;
	localparam logic [7:0]  UNMAPPED_VALUE         = 8'h00;
	// option upper byte field positions
	localparam int BAT_MON_EN_BIT   = 7;
	localparam int LP_HOT_EN_BIT    = 6;
	localparam int SPS_CFG_HI_BIT   = 5;
	localparam int SPS_CFG_LO_BIT   = 4;
	localparam int INPUT_SEL_BIT    = 3;
	localparam int CHARGE_SEL_BIT   = 2;
	localparam int SPS_GAIN_BIT     = 1;
	// system power sense configuration codes
	localparam logic [1:0] SPS_BUS_PLUS_BAT = 2'h0;
	localparam logic [1:0] SPS_BUS_ONLY     = 2'h1;
	// code widths
	localparam int SHORT_CODE_W = 7;
	localparam int CODE_W       = 8;
	localparam int NUM_CH       = 6;
	// conversion channel strobe positions
	localparam int CH_DISCHARGE = 0;
	localparam int CH_CHARGE    = 1;
	localparam int CH_COMPARE   = 2;
	localparam int CH_INPUT     = 3;
	localparam int CH_BATTERY   = 4;
	localparam int CH_SYSTEM    = 5;
	// result step sizes (mA, mV) and voltage offsets (mV)
	localparam logic [9:0]  CHARGE_LSB_10M_MA    = 10'h040;
	localparam logic [9:0]  CHARGE_LSB_5M_MA     = 10'h080;
	localparam logic [9:0]  DISCHARGE_LSB_10M_MA = 10'h100;
	localparam logic [9:0]  DISCHARGE_LSB_5M_MA  = 10'h200;
	localparam logic [9:0]  INPUT_LSB_10M_MA     = 10'h032;
	localparam logic [9:0]  INPUT_LSB_5M_MA      = 10'h064;
	localparam logic [3:0]  COMPARE_LSB_LOW_MV   = 4'h8;
	localparam logic [3:0]  COMPARE_LSB_HIGH_MV  = 4'hc;
	localparam logic [13:0] VOLT_OFFSET_4S_MV    = 14'h0b40;
	localparam logic [13:0] VOLT_OFFSET_5S_MV    = 14'h1fe0;
	// serial bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// >>> tb/cadc_host.sv
// serial bus host model: drives the bus clock and releases or pulls data
module cadc_host
(
	// clock
	input  wire logic clk_i,
	// resolved data line
	input  wire logic sda_i,
	// host pin drives, high means released
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// both lines released while idle
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// wait falling clock edges
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// data changes only while the bus clock is low, sampled mid high
	task automatic clk_bit(input logic b, output logic r);
		sda_o = b;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		tick(2);
		scl_o = 1'b0;
		tick(1);
	endtask
	// start or repeated start: data falls while clock is high
	task automatic start();
		sda_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b0;
		tick(1);
	endtask
	// stop: data rises while clock is high
	task automatic stop();
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask
	// send a byte msb first, return the target's acknowledge
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = ~r;
	endtask
	// receive a byte, then acknowledge or, on the last, refuse
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(last, r);
	endtask
endmodule

// >>> tb/cadc_top_asserts.sv
// checker for control outputs and result scaling of the register bank
module cadc_top_asserts
(
	// clock, reset, enable
	input  wire logic        SYS_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        CE_I,
	// operating conditions
	input  wire logic        LOW_POWER_MODE_ENABLE_I,
	input  wire logic        FIVE_CELL_I,
	input  wire logic        CONVERTER_FULL_SCALE_SELECT_I,
	// analog controls
	input  wire logic        BATTERY_CURRENT_MONITOR_EN_O,
	input  wire logic        SYSTEM_POWER_SENSE_EN_O,
	input  wire logic [1:0]  SYSTEM_POWER_SENSE_CONFIG_O,
	input  wire logic        INPUT_SENSE_RESISTOR_SELECT_O,
	input  wire logic        CHARGE_SENSE_RESISTOR_SELECT_O,
	// result scaling
	input  wire logic [9:0]  CHARGE_LSB_MA_O,
	input  wire logic [9:0]  DISCHARGE_LSB_MA_O,
	input  wire logic [9:0]  INPUT_LSB_MA_O,
	input  wire logic [3:0]  COMPARE_LSB_MV_O,
	input  wire logic [13:0] VOLTAGE_OFFSET_MV_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);
	// low power request taken on an enabled edge
	sequence s_low_power;
		CE_I && LOW_POWER_MODE_ENABLE_I;
	endsequence
	// low power gates both buffers on the next edge
	a_mon_low_power: assert property (
		s_low_power |=> !BATTERY_CURRENT_MONITOR_EN_O)
		else $error("monitor buffer on in low power mode");
	a_sense_low_power: assert property (
		s_low_power |=> !SYSTEM_POWER_SENSE_EN_O)
		else $error("power sensing on in low power mode");
	// sensing is only on for the two active codes
	a_sense_cfg_on: assert property (
		SYSTEM_POWER_SENSE_EN_O |-> !SYSTEM_POWER_SENSE_CONFIG_O[1])
		else $error("power sensing on with an off code");
	// step sizes follow the resistor selects
	a_charge_scale: assert property (
		CHARGE_LSB_MA_O == (CHARGE_SENSE_RESISTOR_SELECT_O ? 10'h080 : 10'h040))
		else $error("charge step disagrees with select");
	a_dis_scale: assert property (
		DISCHARGE_LSB_MA_O == (CHARGE_SENSE_RESISTOR_SELECT_O ? 10'h200 : 10'h100))
		else $error("discharge step disagrees with select");
	a_input_scale: assert property (
		INPUT_LSB_MA_O == (INPUT_SENSE_RESISTOR_SELECT_O ? 10'h064 : 10'h032))
		else $error("input step disagrees with select");
	// pin voltage step and offsets track their inputs one edge later
	a_cmp_scale: assert property (
		CE_I |=> COMPARE_LSB_MV_O ==
		($past(CONVERTER_FULL_SCALE_SELECT_I) ? 4'hc : 4'h8))
		else $error("pin voltage step wrong");
	a_volt_offset: assert property (
		CE_I |=> VOLTAGE_OFFSET_MV_O ==
		($past(FIVE_CELL_I) ? 14'h1fe0 : 14'h0b40))
		else $error("voltage offset wrong");
endmodule
bind cadc_top cadc_top_asserts cadc_top_asserts_i
(
	.SYS_CLK_I,
	.NRST_I,
	.CE_I,
	.LOW_POWER_MODE_ENABLE_I,
	.FIVE_CELL_I,
	.CONVERTER_FULL_SCALE_SELECT_I,
	.BATTERY_CURRENT_MONITOR_EN_O,
	.SYSTEM_POWER_SENSE_EN_O,
	.SYSTEM_POWER_SENSE_CONFIG_O,
	.INPUT_SENSE_RESISTOR_SELECT_O,
	.CHARGE_SENSE_RESISTOR_SELECT_O,
	.CHARGE_LSB_MA_O,
	.DISCHARGE_LSB_MA_O,
	.INPUT_LSB_MA_O,
	.COMPARE_LSB_MV_O,
	.VOLTAGE_OFFSET_MV_O
);

// >>> tb/tb.sv
// self-checking bench for the charger result and option register bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] DEV = 7'h2a; // arbitrary bus address
	// stimulus
	logic        clk;
	logic        nrst = 1'b0;
	logic        scl;
	logic        host_sda;
	logic        sda_line;
	logic [5:0]  conv_done = 6'h00;
	logic [6:0]  chg = 7'h00;
	logic [7:0]  dis = 8'h00, inc = 8'h00, cmp = 8'h00;
	logic [7:0]  sys = 8'h00, bat = 8'h00;
	logic        lp = 1'b0, five = 1'b0, fs = 1'b0;
	// observed outputs
	logic        sda_oe, mon, hot, sen, gain, insel, chsel;
	logic [1:0]  cfg;
	logic [9:0]  chg_lsb, dis_lsb, in_lsb;
	logic [3:0]  cmp_lsb;
	logic [13:0] volt_off;
	// bookkeeping
	int          fail_count = 0, n_tests = 0;
	logic [7:0]  rb [8];
	logic [7:0]  opts [5] = '{8'h81, 8'h96, 8'h5c, 8'he8, 8'hb2};
	// open-drain data line with pull-up
	assign sda_line = host_sda & ~sda_oe;
	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	cadc_host cadc_host_i (.clk_i(clk), .sda_i(sda_line), .scl_o(scl),
		.sda_o(host_sda));
	cadc_top #(.DEV_ADDR(DEV)) cadc_top_i (.SYS_CLK_I(clk), .NRST_I(nrst),
		.CE_I(1'b1), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(),
		.SDA_OE_O(sda_oe), .CONV_DONE_I(conv_done), .CHARGE_CURRENT_I(chg),
		.DISCHARGE_CURRENT_I(dis), .INPUT_CURRENT_I(inc),
		.COMPARATOR_INPUT_PIN_I(cmp), .SYSTEM_VOLTAGE_I(sys),
		.BATTERY_VOLTAGE_I(bat), .LOW_POWER_MODE_ENABLE_I(lp),
		.FIVE_CELL_I(five), .CONVERTER_FULL_SCALE_SELECT_I(fs),
		.BATTERY_CURRENT_MONITOR_EN_O(mon), .LOW_POWER_HOT_SIGNAL_EN_O(hot),
		.SYSTEM_POWER_SENSE_EN_O(sen), .SYSTEM_POWER_SENSE_CONFIG_O(cfg),
		.SYSTEM_POWER_GAIN_SELECT_O(gain),
		.INPUT_SENSE_RESISTOR_SELECT_O(insel),
		.CHARGE_SENSE_RESISTOR_SELECT_O(chsel), .CHARGE_LSB_MA_O(chg_lsb),
		.DISCHARGE_LSB_MA_O(dis_lsb), .INPUT_LSB_MA_O(in_lsb),
		.COMPARE_LSB_MV_O(cmp_lsb), .VOLTAGE_OFFSET_MV_O(volt_off));
	// verdict and end of run
	task automatic wrap_up();
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// compare a byte read over the bus
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_port({8'h00, got}, {8'h00, exp});
	endtask
	// compare a value seen on the output pins
	task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// register write: address, pointer, data
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic a;
		cadc_host_i.start();
		cadc_host_i.put({DEV, 1'b0}, a);
		cadc_host_i.put(p, a);
		cadc_host_i.put(d, a);
		cadc_host_i.stop();
	endtask
	// burst read of n bytes from pointer p, last byte refused
	task automatic rd(input logic [7:0] p, input int n);
		logic a;
		cadc_host_i.start();
		cadc_host_i.put({DEV, 1'b0}, a);
		cadc_host_i.put(p, a);
		cadc_host_i.start();
		cadc_host_i.put({DEV, 1'b1}, a);
		for (int i = 0; i < n; i++)
			cadc_host_i.get(i == n - 1, rb[i]);
		cadc_host_i.stop();
	endtask
	// option word and control outputs after reset
	task automatic t_reset();
		rd(8'h30, 2);
		cmp_byte(rb[0], 8'h00);
		cmp_byte(rb[1], 8'h3f);
		cmp_port({mon, hot, sen, cfg, gain, insel, chsel}, 16'h001f);
		cmp_port({dis_lsb, in_lsb[5:0]}, {10'h200, 6'h24});
	endtask
	// option codes with low power toggled between writes
	task automatic t_option();
		logic [7:0] v;
		for (int i = 0; i < 5; i++)
		begin
			v = opts[i];
			lp = i[0];
			wr(8'h31, v); // codes cover all four sensing configurations
			rd(8'h31, 1);
			cmp_byte(rb[0], v);
			cmp_port({mon, hot, sen, cfg, gain, insel, chsel}, {v[7] & ~lp,
				v[6], ~lp & ~v[5], v[5:4], v[1], v[3], v[2]});
			cmp_port(chg_lsb, v[2] ? 16'h0080 : 16'h0040);
			cmp_port(dis_lsb, v[2] ? 16'h0200 : 16'h0100);
			cmp_port(in_lsb, v[3] ? 16'h0064 : 16'h0032);
		end
		lp = 1'b0;
	endtask
	// results load on strobe, hold, ignore writes, clamp discharge
	task automatic t_results();
		logic [7:0] raw [4] = '{8'h7e, 8'h7f, 8'h80, 8'hff};
		{dis, chg, cmp, inc, bat, sys} = {8'hc5, 7'h55, 32'hff803c00};
		conv_done = 6'h3f;
		@(negedge clk);
		conv_done = 6'h00;
		{chg, inc} = {7'h2a, 8'h11};
		wr(8'h29, 8'haa);
		rd(8'h28, 7);
		cmp_byte(rb[0], 8'h7f);
		cmp_byte(rb[1], 8'h55);
		cmp_byte(rb[2], 8'hff);
		cmp_byte(rb[3], 8'h80);
		cmp_byte(rb[4], 8'h3c);
		cmp_byte(rb[5], 8'h00);
		cmp_byte(rb[6], 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			dis = raw[i];
			conv_done = 6'h01;
			@(negedge clk);
			conv_done = 6'h00;
			rd(8'h28, 1);
			cmp_byte(rb[0], raw[i][7] ? 8'h7f : raw[i]);
		end
	endtask
	// step and offset follow full-scale and cell count
	task automatic t_scale();
		for (int i = 0; i < 4; i++)
		begin
			{five, fs} = i[1:0];
			@(negedge clk);
			cmp_port(cmp_lsb, fs ? 16'h000c : 16'h0008);
			cmp_port(volt_off, five ? 16'h1fe0 : 16'h0b40);
		end
	endtask
	// hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_option();
		t_results();
		t_scale();
		wrap_up();
	end
endmodule
